// File: rtl/rcsc_defs.vh
// Purpose: Shared constants of the reset and clock source control block.
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses.
// Notes:   Offsets are byte addresses of aligned words.
`ifndef RCSC_DEFS_VH
`define RCSC_DEFS_VH

// Register byte offsets
`define RCSC_OFF_PBOR      8'h00
`define RCSC_OFF_CAUSE     8'h04
`define RCSC_OFF_SRST0     8'h08
`define RCSC_OFF_SRST1     8'h0c
`define RCSC_OFF_SRST2     8'h10
`define RCSC_OFF_SYSRST    8'h14
`define RCSC_OFF_WDCTL     8'h18
`define RCSC_OFF_WDLOAD    8'h1c
`define RCSC_OFF_WDVAL     8'h20
`define RCSC_OFF_LDO       8'h24
`define RCSC_OFF_CLK       8'h28
`define RCSC_OFF_STAT      8'h2c

// Field positions
`define RCSC_PBOR_RSTEN    1
`define RCSC_PBOR_IRQFLAG  2
`define RCSC_CAUSE_EXT     0
`define RCSC_CAUSE_POR     1
`define RCSC_CAUSE_BOR     2
`define RCSC_CAUSE_WDT     3
`define RCSC_CAUSE_SW      4
`define RCSC_WD_EN         0
`define RCSC_WD_RSTEN      1
`define RCSC_WD_INTCLR     2
`define RCSC_CLK_BYPASS    0
`define RCSC_CLK_MOSCEN    1
`define RCSC_CLK_USEEXT    2

// Reset values
`define RCSC_PBOR_RST      32'h0000_0000
`define RCSC_WDLOAD_RST    32'hffff_ffff
`define RCSC_LDO_RST       6'h00
`define RCSC_CLK_SRC_RST   2'h1
`define RCSC_CLK_EXT_RST   3'h1

// Clock source codes
`define RCSC_SRC_MAIN      2'h0
`define RCSC_SRC_INT       2'h1
`define RCSC_SRC_INTDIV4   2'h2
`define RCSC_SRC_LFINT     2'h3
`define RCSC_EXT_RTC       3'h7
`define RCSC_SEL_MAIN      3'h0
`define RCSC_SEL_INT       3'h1
`define RCSC_SEL_INTDIV4   3'h2
`define RCSC_SEL_LFINT     3'h3
`define RCSC_SEL_PLL       3'h4
`define RCSC_SEL_RTC       3'h5

// Timing: internal reset held for this many ns after last source
`define RCSC_RST_HOLD_NS   16
// Sized to the 3-bit hold counter: 16 ns at 4 ns a cycle
`define RCSC_RST_HOLD_CYC  3'h4

`endif

// File: rtl/rcsc_top.v
// Purpose: Reset gathering, regulator adjust and clock source select logic.
// Assumes: sys_clk 250 MHz; AXI4-Lite slave; inputs synchronous to sys_clk.
// Notes:   The clock select is a code to the clock mux, not a glitch-free mux.
// Summary of operation
// R01 - Brown-out reset is disabled at reset; software must enable it.
// R02 - Brown-out gives interrupt flag or system reset by software setting.
// R03 - Brown-out causes reset only while reset-enable bit is set.
// R04 - Brown-out reset acts like external reset, held while low supply lasts.
// R05 - A brown-out reset is recorded in the cause register.
// R06 - Cause bits sticky; power-on clears others, leaves power-on bit.
// R07 - Per-peripheral reset bit in three registers; set then clear resets it.
// R08 - Reset bit position equals that peripheral's clock-gating bit position.
// R09 - Peripheral reset drives all clock-domain resets of that unit.
// R10 - System reset request bit asserts full internal reset including core.
// R11 - Watchdog interrupts on first time-out, resets on second.
// R12 - After first time-out, 32-bit counter reloads from reload value.
// R13 - Watchdog reset only if interrupt uncleared and reset output enabled.
// R14 - Regulator adjust field picks regulator output in small steps.
// R15 - Internal oscillator clocks the device after power-on; main oscillator off.
// R16 - Software enables main oscillator and waits before switching to it.
// R17 - System clock from fundamental oscillators, PLL, or internal divided by four.
// R18 - Bypassed codes: 0 main, 1 internal, 2 internal/4, 3 low-frequency.
// R19 - Bypassed with extended select 7 picks real-time oscillator.
// R20 - PLL uses main oscillator only; PLL drives clock when not bypassed, code 0.
// R21 - All sources form one reset: async assert, sync release.
`timescale 1ns/100ps
`include "rcsc_defs.vh"

module rcsc_top #(
	parameter NPERIPH = 32,              // Peripherals per soft reset register
	parameter NDOM    = 2                // Clock domains per peripheral
) (
	input  wire                    sys_clk,        // System clock
	input  wire                    rst,            // Power-on reset, active high
	input  wire                    clkEn,          // Clock enable, freezes state except the reset combiner, hold count and periphReset
	input  wire                    extReset,       // External reset pin level, active high
	input  wire                    brownoutDetect, // Low supply from detector
	input  wire                    mainOscReady,   // Main oscillator stable
	input  wire [31:0]             s_axi_awaddr,   // Write address
	input  wire                    s_axi_awvalid,  // Write address valid
	output reg                     s_axi_awready,  // Write address ready
	input  wire [31:0]             s_axi_wdata,    // Write data
	input  wire [3:0]              s_axi_wstrb,    // Write strobes
	input  wire                    s_axi_wvalid,   // Write data valid
	output reg                     s_axi_wready,   // Write data ready
	output reg  [1:0]              s_axi_bresp,    // Write response
	output reg                     s_axi_bvalid,   // Write response valid
	input  wire                    s_axi_bready,   // Write response ready
	input  wire [31:0]             s_axi_araddr,   // Read address
	input  wire                    s_axi_arvalid,  // Read address valid
	output reg                     s_axi_arready,  // Read address ready
	output reg  [31:0]             s_axi_rdata,    // Read data
	output reg  [1:0]              s_axi_rresp,    // Read response
	output reg                     s_axi_rvalid,   // Read response valid
	input  wire                    s_axi_rready,   // Read response ready
	output reg                     sysResetOut,    // Internal system reset, active high
	output reg  [3*NPERIPH*NDOM-1:0] periphReset,  // Per-peripheral, per-domain resets
	output reg                     brownoutIrq,    // Brown-out interrupt level
	output reg                     watchdogIrq,    // Watchdog first time-out interrupt
	output reg  [5:0]              regulatorAdjust,// Regulator voltage step code
	output reg                     mainOscEnable,  // Main oscillator enable
	output reg  [2:0]              clockSelect,    // Clock mux selection
	output reg                     pllEnable       // PLL running, main oscillator reference
);

	localparam NSR = 3 * NPERIPH;

	// Software state
	reg         brownoutResetEnable;
	reg         brownoutIrqFlag;
	reg  [4:0]  resetCause;
	reg  [NSR-1:0] softReset;
	reg         sysResetRequest;
	reg         wdEnable;
	reg         wdResetEnable;
	reg  [31:0] wdLoad;
	reg  [31:0] wdCount;
	reg         wdFirst;
	reg         wdFire;
	reg         oscBypass;
	reg  [1:0]  oscSource;
	reg  [2:0]  oscSourceExt;
	reg         useExt;
	reg  [2:0]  holdCnt;
	reg         resetMeta;
	reg         resetSync;
	reg         porSeen;

	// AXI write state
	reg         awHeld;
	reg         wHeld;
	reg  [7:0]  awAddr;
	reg  [31:0] wData;
	reg  [3:0]  wStrb;
	reg         awOk;
	wire        doWrite = awHeld && wHeld && !s_axi_bvalid;
	wire        brownoutReset = brownoutDetect && brownoutResetEnable;       // [R03]
	wire        anyReset = extReset || brownoutReset || sysResetRequest || wdFire; // [R04] [R21]

	// Merge byte lanes into a 32-bit old value
	function [31:0] mergeStrb;
		input [31:0] oldV;
		input [31:0] newV;
		input [3:0]  strb;
		integer i;
		begin
			mergeStrb = oldV;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					mergeStrb[i*8 +: 8] = newV[i*8 +: 8];
			end
		end
	endfunction

	// Word decode, shared by read and write paths
	function isMapped;
		input [7:0] a;
		begin
			isMapped = (a[1:0] == 2'h0) && (a <= `RCSC_OFF_STAT);
		end
	endfunction

	// Reset combiner: async assert, sync release after a short hold
	always @(posedge sys_clk or posedge anyReset or posedge rst) begin
		if (rst || anyReset) begin
			resetMeta <= 1'b1;                                           // [R21]
			resetSync <= 1'b1;
		end else begin
			resetMeta <= 1'b0;
			resetSync <= resetMeta;
		end
	end

	// Combined internal reset output with hold count
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			holdCnt     <= 3'h0;
			sysResetOut <= 1'b1;
		end else if (resetSync) begin
			holdCnt     <= 3'h0;
			sysResetOut <= 1'b1;                                         // [R10] [R04]
		end else if (holdCnt != `RCSC_RST_HOLD_CYC) begin
			holdCnt     <= holdCnt + 3'h1;
		end else begin
			sysResetOut <= 1'b0;
		end
	end

	// Peripheral resets: each soft bit drives all domains of its unit
	genvar g, d;
	generate
		for (g = 0; g < NSR; g = g + 1) begin : gPer
			for (d = 0; d < NDOM; d = d + 1) begin : gDom
				always @(posedge sys_clk or posedge rst) begin
					if (rst)
						periphReset[g*NDOM+d] <= 1'b1;
					else
						periphReset[g*NDOM+d] <= softReset[g] | sysResetOut; // [R09] [R07]
				end
			end
		end
	endgenerate

	// Registers; sysResetOut-cleared state covers watchdog and request
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			brownoutResetEnable <= 1'b0;                                 // [R01]
			brownoutIrqFlag     <= 1'b0;
			resetCause          <= 5'h02;                                // [R06]
			porSeen             <= 1'b1;
			softReset           <= {NSR{1'b0}};
			sysResetRequest     <= 1'b0;
			wdEnable            <= 1'b0;
			wdResetEnable       <= 1'b0;
			wdLoad              <= `RCSC_WDLOAD_RST;
			wdCount             <= `RCSC_WDLOAD_RST;
			wdFirst             <= 1'b0;
			wdFire              <= 1'b0;
			regulatorAdjust     <= `RCSC_LDO_RST;
			oscBypass           <= 1'b1;                                 // [R15]
			oscSource           <= `RCSC_CLK_SRC_RST;
			oscSourceExt        <= `RCSC_CLK_EXT_RST;
			useExt              <= 1'b0;
			mainOscEnable       <= 1'b0;                                 // [R15]
		end else if (clkEn) begin
			// Record the cause while the reset is live; sticky otherwise
			if (sysResetOut && !porSeen) begin
				if (extReset)      resetCause[`RCSC_CAUSE_EXT] <= 1'b1;
				if (brownoutReset) resetCause[`RCSC_CAUSE_BOR] <= 1'b1;    // [R05]
				if (wdFire)        resetCause[`RCSC_CAUSE_WDT] <= 1'b1;
				if (sysResetRequest) resetCause[`RCSC_CAUSE_SW] <= 1'b1;
			end
			if (!sysResetOut)
				porSeen <= 1'b0;
			// System-wide reset clears request and watchdog only
			if (sysResetOut) begin
				sysResetRequest <= 1'b0;
				wdFire          <= 1'b0;
				wdFirst         <= 1'b0;
				wdEnable        <= 1'b0;
				wdCount         <= wdLoad;
			end else if (wdEnable) begin
				if (wdCount == 32'h0000_0000) begin
					wdCount <= wdLoad;                                   // [R12]
					if (wdFirst && wdResetEnable)
						wdFire <= 1'b1;                                  // [R13] [R11]
					wdFirst <= 1'b1;                                     // [R11]
				end else begin
					wdCount <= wdCount - 32'h0000_0001;
				end
			end
			// Brown-out interrupt when reset path not enabled; set wins
			if (brownoutDetect && !brownoutResetEnable)
				brownoutIrqFlag <= 1'b1;                                 // [R02]
			else if (doWrite && awOk && awAddr == `RCSC_OFF_PBOR && wStrb[0] && wData[2])
				brownoutIrqFlag <= 1'b0;
			if (doWrite && awOk) begin
				case (awAddr)
				`RCSC_OFF_PBOR: begin
					if (wStrb[0])
						brownoutResetEnable <= wData[`RCSC_PBOR_RSTEN];  // [R03]
				end
				`RCSC_OFF_CAUSE: begin
					// Write one to clear; ignored while a cause is being recorded
					if (wStrb[0] && !sysResetOut)
						resetCause <= resetCause & ~wData[4:0];
				end
				`RCSC_OFF_SRST0: softReset[NPERIPH-1:0] <=
					mergeStrb(softReset[NPERIPH-1:0], wData, wStrb);     // [R08]
				`RCSC_OFF_SRST1: softReset[2*NPERIPH-1:NPERIPH] <=
					mergeStrb(softReset[2*NPERIPH-1:NPERIPH], wData, wStrb);
				`RCSC_OFF_SRST2: softReset[NSR-1:2*NPERIPH] <=
					mergeStrb(softReset[NSR-1:2*NPERIPH], wData, wStrb);
				`RCSC_OFF_SYSRST: begin
					if (wStrb[0] && wData[0])
						sysResetRequest <= 1'b1;                         // [R10]
				end
				`RCSC_OFF_WDCTL: begin
					if (wStrb[0]) begin
						wdEnable      <= wdEnable | wData[`RCSC_WD_EN];  // Only cleared by reset
						wdResetEnable <= wData[`RCSC_WD_RSTEN];
						// Clearing the interrupt also services the watchdog
						if (wData[`RCSC_WD_INTCLR] && !(wdEnable && wdCount == 32'h0000_0000))
							wdFirst <= 1'b0;
					end
				end
				`RCSC_OFF_WDLOAD: begin
					wdLoad  <= mergeStrb(wdLoad, wData, wStrb);
					wdCount <= mergeStrb(wdLoad, wData, wStrb);
				end
				`RCSC_OFF_LDO: begin
					if (wStrb[0])
						regulatorAdjust <= wData[5:0];                   // [R14]
				end
				`RCSC_OFF_CLK: begin
					if (wStrb[0]) begin
						oscBypass     <= wData[`RCSC_CLK_BYPASS];
						mainOscEnable <= wData[`RCSC_CLK_MOSCEN];
						useExt        <= wData[`RCSC_CLK_USEEXT];
						oscSource     <= wData[5:4];
					end
					if (wStrb[1])
						oscSourceExt  <= wData[10:8];
				end
				default: ;
				endcase
			end
		end
	end

	// Interrupt outputs straight from flops
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			brownoutIrq <= 1'b0;
			watchdogIrq <= 1'b0;
		end else if (clkEn) begin
			brownoutIrq <= brownoutIrqFlag;
			watchdogIrq <= wdFirst;
		end
	end

	// Clock source decode; software is trusted to wait for oscillator ready
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clockSelect <= `RCSC_SEL_INT;                                // [R15]
			pllEnable   <= 1'b0;
		end else if (clkEn) begin
			pllEnable <= !oscBypass && oscSource == `RCSC_SRC_MAIN && mainOscEnable; // [R20]
			if (!oscBypass)
				clockSelect <= (oscSource == `RCSC_SRC_MAIN) ? `RCSC_SEL_PLL
					: `RCSC_SEL_INT;                                     // [R20] [R17]
			else if (useExt && oscSourceExt == `RCSC_EXT_RTC)
				clockSelect <= `RCSC_SEL_RTC;                            // [R19]
			else begin
				case (oscSource)                                         // [R18]
				`RCSC_SRC_MAIN:    clockSelect <= `RCSC_SEL_MAIN;        // [R16]
				`RCSC_SRC_INT:     clockSelect <= `RCSC_SEL_INT;
				`RCSC_SRC_INTDIV4: clockSelect <= `RCSC_SEL_INTDIV4;
				`RCSC_SRC_LFINT:   clockSelect <= `RCSC_SEL_LFINT;
				default:           clockSelect <= `RCSC_SEL_INT;
				endcase
			end
		end
	end

	// AXI write channel: address and data taken in either order
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			awOk <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (clkEn) begin
			s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !wHeld && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr[7:0];
				// Upper bits judged here: the master may change them once taken
				awOk <= isMapped(s_axi_awaddr[7:0]) && s_axi_awaddr[31:8] == 24'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= awOk ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI read channel
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (clkEn) begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= (isMapped(s_axi_araddr[7:0]) && s_axi_araddr[31:8] == 24'h0)
					? 2'h0 : 2'h2;
				// Out-of-window addresses must not alias onto the map
				if (s_axi_araddr[31:8] != 24'h0)
					s_axi_rdata <= 32'h0000_0000;
				else case (s_axi_araddr[7:0])
				`RCSC_OFF_PBOR:   s_axi_rdata <= {29'h0, brownoutIrqFlag, brownoutResetEnable, 1'b0};
				`RCSC_OFF_CAUSE:  s_axi_rdata <= {27'h0, resetCause};
				`RCSC_OFF_SRST0:  s_axi_rdata <= softReset[NPERIPH-1:0];
				`RCSC_OFF_SRST1:  s_axi_rdata <= softReset[2*NPERIPH-1:NPERIPH];
				`RCSC_OFF_SRST2:  s_axi_rdata <= softReset[NSR-1:2*NPERIPH];
				`RCSC_OFF_WDCTL:  s_axi_rdata <= {28'h0, wdFirst, 1'b0, wdResetEnable, wdEnable};
				`RCSC_OFF_WDLOAD: s_axi_rdata <= wdLoad;
				`RCSC_OFF_WDVAL:  s_axi_rdata <= wdCount;
				`RCSC_OFF_LDO:    s_axi_rdata <= {26'h0, regulatorAdjust};
				`RCSC_OFF_CLK:    s_axi_rdata <= {21'h0, oscSourceExt, 2'h0, oscSource,
					1'b0, useExt, mainOscEnable, oscBypass};
				`RCSC_OFF_STAT:   s_axi_rdata <= {26'h0, clockSelect, mainOscReady, brownoutDetect,
					sysResetOut};
				default:          s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// File: tb/rcsc_top_sva.sv
// Purpose: Concurrent checks on the reset and clock source block ports.
// Assumes: A register write hands over address and data at one edge.
// Notes:   The brown-out reset enable is shadowed from bus writes.
`timescale 1ns/100ps
module rcsc_top_sva #(
	parameter NPERIPH = 32, // Peripherals per register
	parameter NDOM    = 2   // Domains per peripheral
) (
	input wire                      sys_clk,        // Clock
	input wire                      rst,            // Power-on reset
	input wire                      clkEn,          // Run enable
	input wire                      extReset,       // Pin reset
	input wire                      brownoutDetect, // Low supply
	input wire [31:0]               s_axi_awaddr,   // Write address
	input wire                      s_axi_awvalid,  // Address valid
	input wire                      s_axi_awready,  // Address ready
	input wire [31:0]               s_axi_wdata,    // Write data
	input wire [3:0]                s_axi_wstrb,    // Strobes
	input wire                      s_axi_wvalid,   // Data valid
	input wire                      s_axi_wready,   // Data ready
	input wire                      sysResetOut,    // Internal reset
	input wire [3*NPERIPH*NDOM-1:0] periphReset,    // Unit resets
	input wire                      brownoutIrq,    // Brown-out flag
	input wire                      mainOscEnable,  // Main oscillator on
	input wire [2:0]                clockSelect,    // Clock code
	input wire                      pllEnable       // PLL on
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	reg  borEn;
	wire wrHs;
	// Both write channels taken at one edge
	assign wrHs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	// Shadow of the brown-out reset enable; only power-on reset and bus writes clear it
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			borEn <= 1'b0;
		else if (wrHs && s_axi_awaddr == 32'h0 && s_axi_wstrb[0])
			borEn <= s_axi_wdata[1];
	end
	// Pin held long enough for the reset to be seen before release
	sequence s_extHeld;
		extReset [*3];
	endsequence
	sequence s_swReq;
		wrHs && s_axi_awaddr == 32'h14 && s_axi_wdata[0] && s_axi_wstrb[0];
	endsequence
	property p_borIrq;
		brownoutDetect && !borEn && !sysResetOut && clkEn |-> ##[1:2] brownoutIrq;
	endproperty
	a_borIrq: assert property (p_borIrq) else $error("brown-out flag missing");
	property p_borRst;
		brownoutDetect && borEn |-> ##[0:2] sysResetOut;
	endproperty
	a_borRst: assert property (p_borRst) else $error("brown-out reset missing");
	property p_extRst;
		extReset |-> ##[0:2] sysResetOut;
	endproperty
	a_extRst: assert property (p_extRst) else $error("pin reset missing");
	property p_relHold;
		s_extHeld ##1 !extReset |-> sysResetOut [*3];
	endproperty
	a_relHold: assert property (p_relHold) else $error("reset released early");
	property p_swRst;
		s_swReq |-> ##[1:6] sysResetOut;
	endproperty
	a_swRst: assert property (p_swRst) else $error("software reset missing");
	property p_allPer;
		sysResetOut |=> &periphReset;
	endproperty
	a_allPer: assert property (p_allPer) else $error("unit left out of reset");
	property p_pll;
		pllEnable |-> clockSelect == 3'h4 && mainOscEnable;
	endproperty
	a_pll: assert property (p_pll) else $error("PLL without main oscillator");
	property p_boot;
		$fell(rst) |-> clockSelect == 3'h1 && !mainOscEnable && !pllEnable;
	endproperty
	a_boot: assert property (p_boot) else $error("boot clock not internal");
endmodule

// File: tb/testbench.sv
// Purpose: Self-checking bench for the reset and clock source block.
// Assumes: No fixed bus latency; a cycle ceiling cuts hangs.
// Notes:   Expectations come from small integer models kept here.
`timescale 1ns/100ps
`include "rcsc_defs.vh"
module testbench;
	reg          sys_clk, rst, clkEn, extReset, brownoutDetect, mainOscReady;
	reg          awvalid, wvalid, bready, arvalid, rready;
	reg  [31:0]  awaddr, wdata, araddr, rdat, clkCfg;
	reg  [3:0]   wstrb;
	reg  [1:0]   resp;
	reg  [7:0]   rnd;
	reg  [191:0] expRst, clkTab;
	wire         awready, wready, bvalid, arready, rvalid, sysResetOut;
	wire         brownoutIrq, watchdogIrq, mainOscEnable, pllEnable;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [191:0] periphReset;
	wire [5:0]   regulatorAdjust;
	wire [2:0]   clockSelect;
	integer      miscompares, numChecks, cyc, causeM, i, n, p;
	rcsc_top dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .extReset(extReset),
		.brownoutDetect(brownoutDetect), .mainOscReady(mainOscReady),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .sysResetOut(sysResetOut),
		.periphReset(periphReset), .brownoutIrq(brownoutIrq), .watchdogIrq(watchdogIrq),
		.regulatorAdjust(regulatorAdjust), .mainOscEnable(mainOscEnable),
		.clockSelect(clockSelect), .pllEnable(pllEnable));
	// Free-running 250 MHz clock
	always #2 sys_clk = ~sys_clk;
	function [7:0] lfsr(input [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Clock mux model: PLL wins when not bypassed on the main source
	function [2:0] selM(input [31:0] c);
		selM = (!c[0] && c[5:4] == 2'h0) ? 3'h4 : (c[2] && c[10:8] == 3'h7) ? 3'h5 : {1'b0, c[5:4]};
	endfunction
	task check(input [191:0] seen, input [191:0] exp);
		begin
			numChecks = numChecks + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("Error at %0t ns: got %0h, expected %0h", $time, seen, exp);
			end
		end
	endtask
	// Each channel is released at the edge that takes it; bready is raised with them and held until bvalid
	task wr(input [31:0] a, input [31:0] d);
		begin
			@(posedge sys_clk);
			awaddr <= a;
			wdata <= d;
			{awvalid, wvalid, bready} <= 3'h7;
			do begin
				@(posedge sys_clk);
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (bvalid !== 1'b1);
			bready <= 1'b0;
			resp = bresp;
		end
	endtask
	task rd(input [31:0] a, input [31:0] e, input [1:0] er);
		begin
			@(posedge sys_clk);
			araddr <= a;
			{arvalid, rready} <= 2'h3;
			do begin
				@(posedge sys_clk);
				if (arready) arvalid <= 1'b0;
			end while (rvalid !== 1'b1);
			rready <= 1'b0;
			rdat = rdata;
			check(rdat, e);
			check(rdata ^ rdata ^ rresp, er);
		end
	endtask
	// Counts cycles until: 0 reset high, 1 watchdog flag high, 2 reset low
	task waitFor(input integer w);
		begin
			n = 0;
			while ((w == 0 ? sysResetOut : w == 1 ? watchdogIrq : !sysResetOut) !== 1'b1) begin
				@(posedge sys_clk);
				n = n + 1;
			end
		end
	endtask
	task finalReport;
		begin
			$display("Checks %0d, mismatches %0d", numChecks, miscompares);
			if (miscompares == 0 && numChecks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// Ceiling well above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			finalReport;
		end
	end
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		{clkEn, extReset, brownoutDetect, mainOscReady} = 4'h8;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hf;
		{miscompares, numChecks, cyc} = 96'h0;
		causeM = 2;
		rnd = 8'h15;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		waitFor(2);
		rd(`RCSC_OFF_CAUSE, causeM, 2'h0);
		rd(`RCSC_OFF_PBOR, 32'h0, 2'h0);
		check({clockSelect, mainOscEnable}, 4'h2);
		// Brown-out with the reset path off only raises the flag
		brownoutDetect <= 1'b1;
		repeat (6) @(posedge sys_clk);
		check(sysResetOut, 1'b0);
		check(brownoutIrq, 1'b1);
		brownoutDetect <= 1'b0;
		rd(`RCSC_OFF_PBOR, 32'h4, 2'h0);
		wr(`RCSC_OFF_PBOR, 32'h6);
		rd(`RCSC_OFF_PBOR, 32'h2, 2'h0);
		// Brown-out, then the pin: each holds the reset and is recorded
		for (i = 0; i < 2; i = i + 1) begin
			{extReset, brownoutDetect} <= i ? 2'h2 : 2'h1;
			repeat (12) @(posedge sys_clk);
			check(sysResetOut, 1'b1);
			{extReset, brownoutDetect} <= 2'h0;
			waitFor(2);
			causeM = causeM | (i ? 1 : 4);
			rd(`RCSC_OFF_CAUSE, causeM, 2'h0);
		end
		wr(`RCSC_OFF_PBOR, 32'h0);
		// Clock enable low freezes the flag even while the supply is low
		{clkEn, brownoutDetect} <= 2'h1;
		repeat (4) @(posedge sys_clk);
		check(brownoutIrq, 1'b0);
		{clkEn, brownoutDetect} <= 2'h2;
		repeat (3) @(posedge sys_clk);
		check(brownoutIrq, 1'b0);
		// One random peripheral in each soft reset register
		for (i = 0; i < 3; i = i + 1) begin
			rnd = lfsr(rnd);
			p = i * 32 + rnd[4:0];
			expRst = 192'h0;
			expRst[p*2 +: 2] = 2'h3;
			wr(`RCSC_OFF_SRST0 + 4 * i, 32'h1 << rnd[4:0]);
			repeat (2) @(posedge sys_clk);
			check(periphReset, expRst);
			wr(`RCSC_OFF_SRST0 + 4 * i, 32'h0);
			repeat (2) @(posedge sys_clk);
			check(periphReset, 192'h0);
		end
		rnd = lfsr(rnd);
		wr(`RCSC_OFF_LDO, {26'h0, rnd[5:0]});
		rd(`RCSC_OFF_LDO, {26'h0, rnd[5:0]}, 2'h0);
		check(regulatorAdjust, rnd[5:0]);
		// Main oscillator enabled and ready before any switch onto it
		mainOscReady <= 1'b1;
		clkTab = {32'h113, 32'h103, 32'h123, 32'h133, 32'h717, 32'h102};
		for (i = 0; i < 6; i = i + 1) begin
			clkCfg = clkTab[191 - 32 * i -: 32];
			wr(`RCSC_OFF_CLK, clkCfg);
			repeat (2) @(posedge sys_clk);
			check(clockSelect, selM(clkCfg));
			check(pllEnable, !clkCfg[0] && clkCfg[5:4] == 2'h0);
		end
		// Watchdog: flag on first time-out, reset only once its output is enabled
		wr(`RCSC_OFF_WDLOAD, 32'h14);
		wr(`RCSC_OFF_WDCTL, 32'h1);
		waitFor(1);
		check(n <= 27, 1'b1);
		repeat (50) @(posedge sys_clk);
		check(sysResetOut, 1'b0);
		wr(`RCSC_OFF_WDLOAD, 32'h40);
		wr(`RCSC_OFF_WDCTL, 32'h3);
		waitFor(0);
		check(n >= 52 && n <= 68, 1'b1);
		waitFor(2);
		causeM = causeM | 8;
		rd(`RCSC_OFF_CAUSE, causeM, 2'h0);
		wr(`RCSC_OFF_SYSRST, 32'h1);
		waitFor(0);
		check(n <= 6, 1'b1);
		waitFor(2);
		causeM = causeM | 16;
		rd(`RCSC_OFF_CAUSE, causeM, 2'h0);
		// Unmapped place answers with a slave error
		rd(32'h40, 32'h0, 2'h2);
		wr(32'h40, 32'hffff_ffff);
		check(resp, 2'h2);
		// Second power-on reset wipes the sticky causes
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		waitFor(2);
		rd(`RCSC_OFF_CAUSE, 32'h2, 2'h0);
		check(clockSelect, 3'h1);
		finalReport;
	end
endmodule
bind rcsc_top rcsc_top_sva #(.NPERIPH(NPERIPH), .NDOM(NDOM)) u_sva (.sys_clk(sys_clk),
	.rst(rst), .clkEn(clkEn), .extReset(extReset), .brownoutDetect(brownoutDetect),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .sysResetOut(sysResetOut), .periphReset(periphReset),
	.brownoutIrq(brownoutIrq), .mainOscEnable(mainOscEnable), .clockSelect(clockSelect),
	.pllEnable(pllEnable));
